/* common/idp_params.svh */
/*
  Constants of the identification-page engine: codes, field positions,
  reset values and timing. Definitions only; included by bare name.
*/
`ifndef IDP_PARAMS_SVH
`define IDP_PARAMS_SVH
`define IDP_TYPE_ARRAY 4'hA
`define IDP_TYPE_PAGE 4'hB
`define IDP_ERASED 8'hFF
`define IDP_A10_BIT 2
`define IDP_FREEZE_BIT 1
`define IDP_PAGE_BYTES 64
`define IDP_OFF_W 6
`define IDP_CNT_ACK 4'h8
`define IDP_CNT_MACK 4'h9
`define IDP_Q_KIND 16:14
`define IDP_Q_OFF 13:8
`define IDP_Q_DATA 7:0
`define IDP_WR_TIME_US 5000
`define IDP_REF_MHZ 20
`endif

/* common/idp_pkg.sv */
/*
  Types of the identification-page engine: link states and request kinds.
  Assumes nothing of its surroundings.
*/
package idp_pkg;
  typedef enum logic [6:0]
  {
    ST_IDLE = 7'h01,
    ST_DEV = 7'h02,
    ST_AHI = 7'h04,
    ST_ALO = 7'h08,
    ST_WR = 7'h10,
    ST_RD = 7'h20,
    ST_IGN = 7'h40
  } idp_link_st_e;
  typedef enum logic [2:0]
  {
    K_RD = 3'h0,
    K_WR_FIRST = 3'h1,
    K_WR = 3'h2,
    K_CMT_PAGE = 3'h3,
    K_CMT_FREEZE = 3'h4,
    K_CMT_ARRAY = 3'h5
  } idp_kind_e;
endpackage

/* design/idp_sync2.sv */
/*
  Two-flop level synchroniser, W bits wide.
  Assumes each bit is a level that changes slowly against clk_in.
*/
`timescale 1ns/10ps
`default_nettype none
module idp_sync2
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
    end
    else
    begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
    end
  end
  assign q_out = s2_reg;
endmodule
`default_nettype wire

/* design/idp_fifo2.sv */
/*
  Dual-clock buffer with gray-coded pointers and valid/ready on both sides.
  Assumes DEPTH is a power of two, at least two.
*/
`timescale 1ns/10ps
`default_nettype none
module idp_fifo2
#(
  parameter int W = 8,
  parameter int DEPTH = 2
)
(
  // Filling side
  input wire logic wr_clk_in,
  input wire logic wr_rst_b_in,
  input wire logic wr_valid_in,
  input wire logic [W-1:0] wr_data_in,
  output logic wr_ready_out,
  // Draining side
  input wire logic rd_clk_in,
  input wire logic rd_rst_b_in,
  output logic rd_valid_out,
  output logic [W-1:0] rd_data_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW:0] wbin_reg, wbin_next, wgray_reg, wgray_next, rg_s;
  logic [AW:0] rbin_reg, rbin_next, rgray_reg, rgray_next, wg_s;

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--)
      b[i] = b[i + 1] ^ g[i];
    return b;
  endfunction

  idp_sync2 #(.W(AW + 1)) u_rptr_sync (.clk_in(wr_clk_in), .rst_b_in(wr_rst_b_in), .d_in(rgray_reg), .q_out(rg_s));
  idp_sync2 #(.W(AW + 1)) u_wptr_sync (.clk_in(rd_clk_in), .rst_b_in(rd_rst_b_in), .d_in(wgray_reg), .q_out(wg_s));

  // Full is judged against a stale read pointer, so it only ever errs safe
  assign wr_ready_out = (wbin_reg - g2b(rg_s)) != (AW + 1)'(DEPTH);
  assign rd_valid_out = rgray_reg != wg_s;
  assign rd_data_out = mem_reg[rbin_reg[AW-1:0]];

  always_comb
  begin
    wbin_next = wbin_reg + (AW + 1)'(wr_valid_in & wr_ready_out);
    wgray_next = wbin_next ^ (wbin_next >> 1);
    rbin_next = rbin_reg + (AW + 1)'(rd_valid_out & rd_ready_in);
    rgray_next = rbin_next ^ (rbin_next >> 1);
  end

  always_ff @(posedge wr_clk_in or negedge wr_rst_b_in)
  begin
    if (!wr_rst_b_in)
    begin
      wbin_reg <= '0;
      wgray_reg <= '0;
    end
    else
    begin
      wbin_reg <= wbin_next;
      wgray_reg <= wgray_next;
    end
  end

  always_ff @(posedge wr_clk_in)
  begin
    if (wr_valid_in && wr_ready_out)
      mem_reg[wbin_reg[AW-1:0]] <= wr_data_in;
  end

  always_ff @(posedge rd_clk_in or negedge rd_rst_b_in)
  begin
    if (!rd_rst_b_in)
    begin
      rbin_reg <= '0;
      rgray_reg <= '0;
    end
    else
    begin
      rbin_reg <= rbin_next;
      rgray_reg <= rgray_next;
    end
  end
endmodule
`default_nettype wire

/* design/idp_eeprom_top.sv */
/*
  Identification-page engine of a two-wire serial EEPROM. Protocol logic runs
  on the link sampling clock, page storage and write-cycle timer on ref_clk_in.
  Assumes link_clk_in runs free at eight times SCL or faster, open-drain pins
  with pull-ups, and that rst_b_in stands for the factory-fresh state.
*/
// How it works
// - Page read framed as random read, select nibble carries page code instead of array code.
// - Page reads use address bits five to zero as offset; upper bits ignored.
// - Acknowledge that data byte when unlocked, leave line high when locked.
// - A Start after the probe resets command logic; the truncated write never runs.
// - A Stop returns the device to standby.
// - Fresh device holds all ones in every page byte.
// - Only byte, page, page-write and freeze commands start a write cycle.
// - Freeze is a one-byte page write with A10 set and data bit one set.
// - When frozen, every page-write data byte is refused and page stays intact.
`timescale 1ns/10ps
`default_nettype none
`include "idp_params.svh"
module idp_eeprom_top
#(
  parameter int WR_TIME_US = `IDP_WR_TIME_US,
  parameter int WR_CYCLES = WR_TIME_US * `IDP_REF_MHZ,
  parameter int FIFO_DEPTH = 2
)
(
  // Clocks and reset
  input wire logic ref_clk_in,
  input wire logic link_clk_in,
  input wire logic rst_b_in,
  // Bus clock pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  // Bus data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Chip enable straps
  input wire logic [2:0] chip_en_in,
  // Status
  output logic nv_busy_out,
  output logic page_frozen_out
);
  localparam int TW = $clog2(WR_CYCLES + 1);
  localparam int QW = 17;
  localparam int PB = `IDP_PAGE_BYTES;

  // Link domain
  idp_pkg::idp_link_st_e st_reg, st_next;
  idp_pkg::idp_kind_e pkind_reg, pkind_next, ckind_reg, ckind_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, ld_byte, rdat;
  logic [`IDP_OFF_W-1:0] off_reg, off_next;
  logic idp_reg, idp_next, frz_reg, frz_next, first_reg, first_next;
  logic pend_reg, pend_next, cpend_reg, cpend_next, fetch_reg, fetch_next;
  logic hold_reg, hold_next, sda_oe_reg, sda_oe_next, scl_oe_reg, scl_oe_next;
  logic scl_d_reg, sda_d_reg, low_reg;
  logic scl_s, sda_s, busy_s, frozen_s;
  logic [2:0] ce_s;
  logic start_w, stop_w, rise_w, step_w, load, can_push;
  logic push_v, req_ready, rv, rd_pop;
  logic [QW-1:0] push_d, req_d;
  // Core domain
  logic [7:0] page_reg [PB];
  logic [7:0] stage_reg [PB];
  logic mask_reg [PB];
  logic busy_reg, busy_next, frozen_reg, frozen_next, done;
  logic [TW-1:0] tmr_reg, tmr_next;
  idp_pkg::idp_kind_e cyck_reg, cyck_next, kind_c;
  logic [`IDP_OFF_W-1:0] off_c;
  logic [7:0] dat_c, ret_d;
  logic req_v, req_pop, ret_v, ret_ready;

  idp_sync2 #(.W(2), .RST_VAL(2'h3)) u_pin_sync (.clk_in(link_clk_in), .rst_b_in(rst_b_in),
    .d_in({scl_in, sda_in}), .q_out({scl_s, sda_s}));
  idp_sync2 #(.W(5)) u_stat_sync (.clk_in(link_clk_in), .rst_b_in(rst_b_in),
    .d_in({chip_en_in, busy_reg, frozen_reg}), .q_out({ce_s, busy_s, frozen_s}));

  idp_fifo2 #(.W(QW), .DEPTH(FIFO_DEPTH)) u_req_fifo (.wr_clk_in(link_clk_in), .wr_rst_b_in(rst_b_in),
    .wr_valid_in(push_v), .wr_data_in(push_d), .wr_ready_out(req_ready),
    .rd_clk_in(ref_clk_in), .rd_rst_b_in(rst_b_in), .rd_valid_out(req_v),
    .rd_data_out(req_d), .rd_ready_in(req_pop));
  idp_fifo2 #(.W(8), .DEPTH(FIFO_DEPTH)) u_ret_fifo (.wr_clk_in(ref_clk_in), .wr_rst_b_in(rst_b_in),
    .wr_valid_in(ret_v), .wr_data_in(ret_d), .wr_ready_out(ret_ready),
    .rd_clk_in(link_clk_in), .rd_rst_b_in(rst_b_in), .rd_valid_out(rv),
    .rd_data_out(rdat), .rd_ready_in(rd_pop));

  assign start_w = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_w = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign rise_w = scl_s & ~scl_d_reg;
  // A held step repeats every cycle while SCL is stretched low
  assign step_w = (~scl_s & scl_d_reg) | hold_reg;

  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    off_next = off_reg;
    idp_next = idp_reg;
    frz_next = frz_reg;
    first_next = first_reg;
    pend_next = pend_reg;
    pkind_next = pkind_reg;
    cpend_next = cpend_reg;
    ckind_next = ckind_reg;
    fetch_next = fetch_reg;
    hold_next = hold_reg;
    sda_oe_next = sda_oe_reg;
    scl_oe_next = scl_oe_reg;
    load = 1'b0;
    ld_byte = `IDP_ERASED;
    push_v = 1'b0;
    push_d = {idp_pkg::K_RD, off_reg, sh_reg};
    // Stale read data left by an aborted transfer is drained here
    rd_pop = rv & ~fetch_reg;
    can_push = req_ready & ~cpend_reg;
    if (cpend_reg)
    begin
      push_v = 1'b1;
      push_d = {ckind_reg, off_reg, sh_reg};
      cpend_next = ~req_ready;
    end
    if (start_w)
    begin
      st_next = idp_pkg::ST_DEV;
      cnt_next = '0;
      pend_next = 1'b0;
      fetch_next = 1'b0;
      hold_next = 1'b0;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
    end
    else if (stop_w)
    begin
      st_next = idp_pkg::ST_IDLE;
      cnt_next = '0;
      fetch_next = 1'b0;
      hold_next = 1'b0;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
      if (pend_reg)
      begin
        cpend_next = 1'b1;
        ckind_next = pkind_reg;
        pend_next = 1'b0;
      end
    end
    else if (st_reg != idp_pkg::ST_IDLE && st_reg != idp_pkg::ST_IGN)
    begin
      if (rise_w && cnt_reg < `IDP_CNT_ACK)
      begin
        sh_next = (st_reg == idp_pkg::ST_RD) ? {sh_reg[6:0], 1'b1} : {sh_reg[6:0], sda_s};
        cnt_next = cnt_reg + 4'h1;
      end
      else if (rise_w && cnt_reg == `IDP_CNT_MACK && st_reg == idp_pkg::ST_RD && sda_s)
        st_next = idp_pkg::ST_IGN;
      else if (step_w && cnt_reg == `IDP_CNT_ACK)
      begin
        cnt_next = `IDP_CNT_MACK;
        sda_oe_next = 1'b1;
        unique case (st_reg)
          idp_pkg::ST_DEV:
          begin
            idp_next = sh_reg[7:4] == `IDP_TYPE_PAGE;
            sh_next = sh_reg;
            first_next = 1'b1;
            st_next = sh_reg[0] ? idp_pkg::ST_RD : idp_pkg::ST_AHI;
            // A running write cycle refuses selection so the master can poll
            if (!((sh_reg[7:4] == `IDP_TYPE_PAGE || sh_reg[7:4] == `IDP_TYPE_ARRAY)
                && sh_reg[3:1] == ce_s && !busy_s))
            begin
              st_next = idp_pkg::ST_IGN;
              sda_oe_next = 1'b0;
            end
          end
          idp_pkg::ST_AHI:
          begin
            frz_next = sh_reg[`IDP_A10_BIT];
            st_next = idp_pkg::ST_ALO;
          end
          idp_pkg::ST_ALO:
          begin
            off_next = sh_reg[`IDP_OFF_W-1:0];
            st_next = idp_pkg::ST_WR;
          end
          idp_pkg::ST_WR:
          begin
            if (!idp_reg)
            begin
              pend_next = 1'b1;
              pkind_next = idp_pkg::K_CMT_ARRAY;
            end
            else if (frozen_s || (frz_reg && !first_reg))
            begin
              sda_oe_next = 1'b0;
              pend_next = 1'b0;
              st_next = idp_pkg::ST_IGN;
            end
            else if (frz_reg)
            begin
              first_next = 1'b0;
              pend_next = sh_reg[`IDP_FREEZE_BIT];
              pkind_next = idp_pkg::K_CMT_FREEZE;
            end
            else if (can_push)
            begin
              push_v = 1'b1;
              push_d = {first_reg ? idp_pkg::K_WR_FIRST : idp_pkg::K_WR, off_reg, sh_reg};
              off_next = off_reg + 1'b1;
              first_next = 1'b0;
              pend_next = 1'b1;
              pkind_next = idp_pkg::K_CMT_PAGE;
            end
            else
            begin
              cnt_next = cnt_reg;
              sda_oe_next = 1'b0;
            end
          end
          idp_pkg::ST_RD:
            sda_oe_next = 1'b0;
          default:
            sda_oe_next = 1'b0;
        endcase
        hold_next = cnt_next == cnt_reg;
        scl_oe_next = hold_next;
      end
      else if (step_w && cnt_reg == `IDP_CNT_MACK)
      begin
        if (st_reg == idp_pkg::ST_RD)
        begin
          if (!idp_reg)
            load = 1'b1;
          else if (fetch_reg && rv)
          begin
            load = 1'b1;
            ld_byte = rdat;
            rd_pop = 1'b1;
            fetch_next = 1'b0;
          end
          else if (!fetch_reg && can_push)
          begin
            push_v = 1'b1;
            push_d = {idp_pkg::K_RD, off_reg, sh_reg};
            off_next = off_reg + 1'b1;
            fetch_next = 1'b1;
          end
          hold_next = ~load;
          scl_oe_next = ~load;
          if (load)
          begin
            sh_next = ld_byte;
            sda_oe_next = ~ld_byte[7];
            cnt_next = '0;
          end
        end
        else
        begin
          sda_oe_next = 1'b0;
          cnt_next = '0;
        end
      end
      else if (step_w && st_reg == idp_pkg::ST_RD && cnt_reg != '0)
        sda_oe_next = ~sh_reg[7];
    end
    else if (st_reg == idp_pkg::ST_IGN)
      sda_oe_next = 1'b0;
  end

  always_ff @(posedge link_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st_reg <= idp_pkg::ST_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      off_reg <= '0;
      idp_reg <= 1'b0;
      frz_reg <= 1'b0;
      first_reg <= 1'b0;
      pend_reg <= 1'b0;
      pkind_reg <= idp_pkg::K_CMT_ARRAY;
      cpend_reg <= 1'b0;
      ckind_reg <= idp_pkg::K_CMT_ARRAY;
      fetch_reg <= 1'b0;
      hold_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      low_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      off_reg <= off_next;
      idp_reg <= idp_next;
      frz_reg <= frz_next;
      first_reg <= first_next;
      pend_reg <= pend_next;
      pkind_reg <= pkind_next;
      cpend_reg <= cpend_next;
      ckind_reg <= ckind_next;
      fetch_reg <= fetch_next;
      hold_reg <= hold_next;
      sda_oe_reg <= sda_oe_next;
      scl_oe_reg <= scl_oe_next;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      low_reg <= 1'b0;
    end
  end

  // Core domain: staging, page cells and write-cycle timer
  assign kind_c = idp_pkg::idp_kind_e'(req_d[`IDP_Q_KIND]);
  assign off_c = req_d[`IDP_Q_OFF];
  assign dat_c = req_d[`IDP_Q_DATA];
  assign req_pop = req_v & ~busy_reg & ((kind_c != idp_pkg::K_RD) | ret_ready);
  assign ret_v = req_v & ~busy_reg & (kind_c == idp_pkg::K_RD);
  assign ret_d = page_reg[off_c];
  assign done = busy_reg & (tmr_reg == '0);

  always_comb
  begin
    busy_next = busy_reg;
    tmr_next = tmr_reg;
    cyck_next = cyck_reg;
    frozen_next = frozen_reg | (done & (cyck_reg == idp_pkg::K_CMT_FREEZE));
    if (done)
      busy_next = 1'b0;
    else if (busy_reg)
      tmr_next = tmr_reg - 1'b1;
    else if (req_pop && kind_c >= idp_pkg::K_CMT_PAGE)
    begin
      busy_next = 1'b1;
      tmr_next = TW'(WR_CYCLES - 1);
      cyck_next = kind_c;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      busy_reg <= 1'b0;
      tmr_reg <= '0;
      cyck_reg <= idp_pkg::K_CMT_ARRAY;
      frozen_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= busy_next;
      tmr_reg <= tmr_next;
      cyck_reg <= cyck_next;
      frozen_reg <= frozen_next;
    end
  end

  for (genvar i = 0; i < PB; i++)
  begin : g_cell
    logic [7:0] page_next, stage_next;
    logic mask_next;
    always_comb
    begin
      page_next = page_reg[i];
      stage_next = stage_reg[i];
      mask_next = mask_reg[i] & ~(req_pop & (kind_c == idp_pkg::K_WR_FIRST));
      if (req_pop && (kind_c == idp_pkg::K_WR_FIRST || kind_c == idp_pkg::K_WR) && off_c == `IDP_OFF_W'(i))
      begin
        stage_next = dat_c;
        mask_next = 1'b1;
      end
      if (done && cyck_reg == idp_pkg::K_CMT_PAGE && mask_reg[i] && !frozen_reg)
        page_next = stage_reg[i];
    end
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
      if (!rst_b_in)
      begin
        page_reg[i] <= `IDP_ERASED;
        stage_reg[i] <= `IDP_ERASED;
        mask_reg[i] <= 1'b0;
      end
      else
      begin
        page_reg[i] <= page_next;
        stage_reg[i] <= stage_next;
        mask_reg[i] <= mask_next;
      end
    end
  end

  assign scl_out = low_reg;
  assign sda_out = low_reg;
  assign scl_oe_out = scl_oe_reg;
  assign sda_oe_out = sda_oe_reg;
  assign nv_busy_out = busy_reg;
  assign page_frozen_out = frozen_reg;

  sequence s_page_sel;
    st_reg == idp_pkg::ST_DEV && step_w && cnt_reg == `IDP_CNT_ACK && sh_reg[7:4] == `IDP_TYPE_PAGE
      && sh_reg[3:1] == ce_s && !busy_s;
  endsequence
  sequence s_freeze_done;
    busy_reg && cyck_reg == idp_pkg::K_CMT_FREEZE && tmr_reg == '0;
  endsequence

  a_page_sel_ack:
    assert property (@(posedge link_clk_in) disable iff (!rst_b_in) s_page_sel |=> sda_oe_reg && idp_reg)
    else $error("page select not acknowledged");
  a_offset_low:
    assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
      (st_reg == idp_pkg::ST_ALO && step_w && cnt_reg == `IDP_CNT_ACK) |=> off_reg == $past(sh_reg[5:0]))
    else $error("page offset not taken from low address bits");
  a_frozen_nack:
    assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
      (st_reg == idp_pkg::ST_WR && step_w && cnt_reg == `IDP_CNT_ACK && idp_reg && frozen_s)
      |=> !sda_oe_reg && st_reg == idp_pkg::ST_IGN ##1 !sda_oe_reg)
    else $error("frozen page data byte acknowledged");
  a_start_drops:
    assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
      (start_w && pend_reg) |=> (!pend_reg && !cpend_reg) [*2])
    else $error("truncated write survived a start");
  a_stop_idle:
    assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
      stop_w |=> st_reg == idp_pkg::ST_IDLE && !sda_oe_reg && !scl_oe_reg)
    else $error("stop did not return to standby");
  a_erased_reset:
    assert property (@(posedge ref_clk_in) $rose(rst_b_in) |-> page_reg[0] == `IDP_ERASED && !frozen_reg)
    else $error("page not erased after reset");
  a_cycle_start:
    assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      (req_pop && !busy_reg) |=> busy_reg == ($past(kind_c) >= idp_pkg::K_CMT_PAGE))
    else $error("write cycle started by wrong command");
  a_freeze_sets:
    assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) s_freeze_done |=> frozen_reg && !busy_reg)
    else $error("freeze command did not freeze the page");
  a_page_kept:
    assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) frozen_reg |=> $stable(page_reg[0]))
    else $error("frozen page changed");
  a_frozen_stays:
    assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) frozen_reg |=> frozen_reg)
    else $error("page unfroze");
endmodule
`default_nettype wire

/* dv/idp_master_bfm.sv */
/* Two-wire bus master model, open-drain, honours clock stretching.
   Assumes pull-ups: the bench resolves both wires. */
`timescale 1ns/10ps
`default_nettype none
module idp_master_bfm
(
  // Resolved wires
  input wire logic scl_in,
  input wire logic sda_in,
  // Drive, 1 = released
  output logic scl_out,
  output logic sda_out
);
  localparam int Q = 500;
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Device may stretch; bounded wait so a stuck line ends the bit
  task automatic hi();
    int n;
    n = 0;
    scl_out = 1'b1;
    while (scl_in !== 1'b1 && n < 400)
    begin
      #10;
      n++;
    end
    #Q;
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_out = b;
    #Q;
    hi();
    s = sda_in;
    #Q;
    scl_out = 1'b0;
  endtask
  task automatic start();
    sda_out = 1'b1;
    #Q;
    hi();
    sda_out = 1'b0;
    #Q;
    scl_out = 1'b0;
  endtask
  task automatic stop();
    sda_out = 1'b0;
    #Q;
    hi();
    sda_out = 1'b1;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(output logic [7:0] b, input logic m_ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(~m_ack, s);
  endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
/* Self-checking bench of the identification-page engine.
   Assumes the master model in idp_master_bfm and pull-ups on both wires. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [2:0] chip_en_in = 3'h5;
  logic scl_oe, scl_o, sda_oe, sda_o, m_scl, m_sda, busy, frozen, a;
  wire scl_w = m_scl & (scl_oe ? scl_o : 1'b1);
  wire sda_w = m_sda & (sda_oe ? sda_o : 1'b1);
  int n_errors = 0;
  int n_checks = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  // Link clock edges hold a fixed phase to core clock edges; every second link edge coincides with a core edge
  always #62.5 link_clk_in = ~link_clk_in;
  idp_eeprom_top #(.WR_CYCLES(50)) i_dut (.ref_clk_in(ref_clk_in), .link_clk_in(link_clk_in),
    .rst_b_in(rst_b_in), .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .chip_en_in(chip_en_in), .nv_busy_out(busy),
    .page_frozen_out(frozen));
  idp_master_bfm i_mst (.scl_in(scl_w), .sda_in(sda_w), .scl_out(m_scl), .sda_out(m_sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Start, write select, both address bytes
  task automatic addr_wr(input logic [7:0] hi, input logic [7:0] lo);
    i_mst.start();
    i_mst.wbyte({4'hB, 3'h5, 1'b0}, a);
    chk(a, 1, "sel ack");
    i_mst.wbyte(hi, a);
    i_mst.wbyte(lo, a);
  endtask
  task automatic rd_chk(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] e0,
    input logic [7:0] e1);
    logic [7:0] d;
    addr_wr(hi, lo);
    i_mst.start();
    i_mst.wbyte({4'hB, 3'h5, 1'b1}, a);
    chk(a, 1, "rd sel ack");
    i_mst.rbyte(d, 1'b1);
    chk(d, e0, "rd byte 0");
    i_mst.rbyte(d, 1'b0);
    chk(d, e1, "rd byte 1");
    i_mst.stop();
  endtask
  task automatic wait_nv();
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(busy, 1, "cycle start");
    n = 0;
    while (busy !== 1'b0 && n < 200)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(busy, 0, "cycle end");
  endtask
  task automatic t_fresh();
    // Upper address bits set on purpose: only offset 0Ah may count
    rd_chk(8'h3B, 8'hCA, 8'hFF, 8'hFF);
  endtask
  task automatic t_write();
    addr_wr(8'h00, 8'h03);
    i_mst.wbyte(8'h5A, a);
    i_mst.wbyte(8'hA5, a);
    chk(a, 1, "wr ack");
    i_mst.stop();
    wait_nv();
    rd_chk(8'hF8, 8'h43, 8'h5A, 8'hA5);
  endtask
  task automatic t_probe(input logic exp);
    addr_wr(8'h00, 8'h07);
    i_mst.wbyte(8'h11, a);
    chk(a, exp, "lock probe");
    i_mst.start();
    i_mst.stop();
    #4000;
    chk(busy, 0, "probe no cycle");
    rd_chk(8'h00, 8'h07, 8'hFF, 8'hFF);
  endtask
  task automatic t_freeze();
    addr_wr(8'h04, 8'h00);
    i_mst.wbyte(8'h02, a);
    chk(a, 1, "freeze ack");
    i_mst.stop();
    wait_nv();
    chk(frozen, 1, "frozen");
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk_in);
    #2 rst_b_in = 1'b1;
    #2000;
    t_fresh();
    t_write();
    t_probe(1'b1);
    t_freeze();
    t_probe(1'b0);
    rd_chk(8'h00, 8'h03, 8'h5A, 8'hA5);
    end_sim();
  end
  initial
  begin
    #4000000;
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
